// ==== hdl/vwl_map.vh ====
// Register offsets, field positions and reset values of the video write control block
`ifndef VWL_MAP_VH
`define VWL_MAP_VH

// Port-local register offsets (8-bit address)
`define VWL_OFF_STATUS      8'h00
`define VWL_OFF_LOGIC       8'hb0
`define VWL_OFF_MODE0       8'hc0
`define VWL_OFF_MODE1       8'hd0
// Host address space (octal 173000, 174540, 174600 and a chosen 174620)
`define VWL_HOST_STATUS     16'hf600
`define VWL_HOST_LOGIC      16'hf960
`define VWL_HOST_MODE0      16'hf980
`define VWL_HOST_MODE1      16'hf990

// Status bits
`define VWL_ST_HBLANK       6
`define VWL_ST_VRETRACE     5
`define VWL_ST_DMA          4
`define VWL_ST_DRAW         3
`define VWL_ST_EMPTY        2
`define VWL_ST_FULL         1
`define VWL_ST_DREADY       0

// Mode select 0 fields
`define VWL_MS0_ERASE_DIS   7
`define VWL_MS0_PATSRC      6
`define VWL_MS0_READBACK    5
`define VWL_MS0_LU_ROUTE    4
`define VWL_MS0_VECTOR      3
`define VWL_MS0_OUT_EN      2
`define VWL_MS0_MAP_HI      1
`define VWL_MS0_MAP_LO      0

// Mode select 1 fields
`define VWL_MS1_SE_HI       3
`define VWL_MS1_SE_LO       2
`define VWL_MS1_DIR         1

// Scroll/erase mode codes
`define VWL_SE_OFF          2'b00
`define VWL_SE_UNUSED       2'b01
`define VWL_SE_LINE_ERASE   2'b10
`define VWL_SE_DMA_SCROLL   2'b11

// Logic unit fields
`define VWL_LU_OP_HI        7
`define VWL_LU_OP_LO        6
`define VWL_LU_FG1          5
`define VWL_LU_FG0          4
`define VWL_LU_BG1          3
`define VWL_LU_BG0          2
`define VWL_LU_SINGLE       1
`define VWL_LU_PICK         0

// Write operation codes
`define VWL_OP_REPLACE      2'b00
`define VWL_OP_UNUSED       2'b01
`define VWL_OP_OVERLAY      2'b10
`define VWL_OP_COMPLEMENT   2'b11

// Reset values: erase disabled, display on, all else zero
`define VWL_RST_MODE0       8'h84
`define VWL_RST_MODE1       8'h00
`define VWL_RST_LOGIC       8'h00
`endif

// ==== hdl/vwl_port_dec.v ====
// Register select decode for one processor port
`timescale 1ns/100ps
`include "vwl_map.vh"
module vwl_port_decode #(
	parameter AW = 8,
	parameter [AW-1:0] A_STATUS = 0,
	parameter [AW-1:0] A_LOGIC = 0,
	parameter [AW-1:0] A_MODE0 = 0,
	parameter [AW-1:0] A_MODE1 = 0
) (
	// Access strobes
	input  wire          sel,
	input  wire          wr,
	input  wire [AW-1:0] addr,
	// Decoded selects
	output wire          rd_status,
	output wire          wr_logic,
	output wire          wr_mode0,
	output wire          wr_mode1
);
	assign rd_status = sel & ~wr & (addr == A_STATUS);
	assign wr_logic  = sel & wr & (addr == A_LOGIC);
	assign wr_mode0  = sel & wr & (addr == A_MODE0);
	assign wr_mode1  = sel & wr & (addr == A_MODE1);
endmodule

// ==== hdl/vwl_plane_drive.v ====
// Per-plane write level and operation decode
`timescale 1ns/100ps
`include "vwl_map.vh"
module vwl_plane_drive (
	// Logic unit register
	input  wire [7:0] logic_reg,
	// Plane controls
	output wire [1:0] fg_level,
	output wire [1:0] bg_level,
	output wire [1:0] plane_wr_en,
	output wire       op_replace,
	output wire       op_overlay,
	output wire       op_complement
);
	wire [1:0] op;
	wire       single;
	wire       pick;

	assign op = {logic_reg[`VWL_LU_OP_HI], logic_reg[`VWL_LU_OP_LO]};
	assign single = logic_reg[`VWL_LU_SINGLE];
	assign pick = logic_reg[`VWL_LU_PICK];
	assign fg_level = {logic_reg[`VWL_LU_FG1], logic_reg[`VWL_LU_FG0]};
	assign bg_level = {logic_reg[`VWL_LU_BG1], logic_reg[`VWL_LU_BG0]};
	// Single plane writes only the picked plane
	assign plane_wr_en = single ? {pick, ~pick} : 2'b11;
	// Unused code 01 falls back to no operation flagged
	assign op_replace = (op == `VWL_OP_REPLACE);
	assign op_overlay = (op == `VWL_OP_OVERLAY);
	assign op_complement = (op == `VWL_OP_COMPLEMENT);
endmodule

// ==== hdl/vwl_ctrl.v ====
`timescale 1ns/100ps
`include "vwl_map.vh"
module vwl_ctrl (
	// Clock and reset
	input  wire        CLK_SYS,
	input  wire        RST,
	// Host processor port
	input  wire        HOST_SEL,
	input  wire        HOST_WR,
	input  wire [15:0] HOST_ADDR,
	input  wire [7:0]  HOST_WDATA,
	output reg  [7:0]  HOST_RDATA,
	// Display processor port
	input  wire        DISP_SEL,
	input  wire        DISP_WR,
	input  wire [7:0]  DISP_ADDR,
	input  wire [7:0]  DISP_WDATA,
	output reg  [7:0]  DISP_RDATA,
	// Drawing controller state
	input  wire        HBLANK,
	input  wire        VRETRACE,
	input  wire        DMA_BUSY,
	input  wire        DRAW_BUSY,
	input  wire        QUEUE_EMPTY,
	input  wire        QUEUE_FULL,
	input  wire        DATA_READY,
	// Video mode controls
	output reg         SCREEN_ERASE_DISABLE,
	output reg         PATTERN_SOURCE_SELECT,
	output reg         READBACK_SELECT,
	output reg         LOGIC_UNIT_ROUTE,
	output reg         VECTOR_MODE_SELECT,
	output reg         TEXT_MASK_ENABLE,
	output reg         BITMAP_OUTPUT_ENABLE,
	output reg         BITMAP_WRITE_ALLOW,
	output reg  [1:0]  PLANE_MAP_SELECT,
	// Scroll and erase
	output reg         LINE_ERASE_ENABLE,
	output reg         DMA_SCROLL_ENABLE,
	output reg         COUNT_DIRECTION,
	// Plane write controls
	output reg  [1:0]  FOREGROUND_LEVEL,
	output reg  [1:0]  BACKGROUND_LEVEL,
	output reg  [1:0]  PLANE_WRITE_ENABLE,
	output reg         OP_REPLACE,
	output reg         OP_OVERLAY,
	output reg         OP_COMPLEMENT
);
	reg  [7:0] mode0_ff;
	reg  [7:0] mode1_ff;
	reg  [7:0] logic_ff;
	reg  [7:0] nxt_mode0;
	reg  [7:0] nxt_mode1;
	reg  [7:0] nxt_logic;
	wire [7:0] status;
	wire       h_rd;
	wire       h_wl;
	wire       h_w0;
	wire       h_w1;
	wire       d_rd;
	wire       d_wl;
	wire       d_w0;
	wire       d_w1;
	wire [1:0] fg;
	wire [1:0] bg;
	wire [1:0] pwe;
	wire       o_rep;
	wire       o_ovl;
	wire       o_cmp;
	wire [1:0] se_mode;

	vwl_port_decode #(
		.AW       (16),
		.A_STATUS (`VWL_HOST_STATUS),
		.A_LOGIC  (`VWL_HOST_LOGIC),
		.A_MODE0  (`VWL_HOST_MODE0),
		.A_MODE1  (`VWL_HOST_MODE1)
	) u_host_decode (
		.sel       (HOST_SEL),
		.wr        (HOST_WR),
		.addr      (HOST_ADDR),
		.rd_status (h_rd),
		.wr_logic  (h_wl),
		.wr_mode0  (h_w0),
		.wr_mode1  (h_w1)
	);

	vwl_port_decode #(
		.AW       (8),
		.A_STATUS (`VWL_OFF_STATUS),
		.A_LOGIC  (`VWL_OFF_LOGIC),
		.A_MODE0  (`VWL_OFF_MODE0),
		.A_MODE1  (`VWL_OFF_MODE1)
	) u_disp_decode (
		.sel       (DISP_SEL),
		.wr        (DISP_WR),
		.addr      (DISP_ADDR),
		.rd_status (d_rd),
		.wr_logic  (d_wl),
		.wr_mode0  (d_w0),
		.wr_mode1  (d_w1)
	);

	// Bit 7 unused, reads zero
	assign status = {1'b0,
		HBLANK,
		VRETRACE,
		DMA_BUSY,
		DRAW_BUSY,
		QUEUE_EMPTY,
		QUEUE_FULL,
		DATA_READY};

	// Display processor wins a same-cycle write clash; it drives the drawing
	always @* begin
		nxt_mode0 = mode0_ff;
		nxt_mode1 = mode1_ff;
		nxt_logic = logic_ff;
		if (h_w0)
			nxt_mode0 = HOST_WDATA;
		if (d_w0)
			nxt_mode0 = DISP_WDATA;
		if (h_w1)
			nxt_mode1 = {4'h0, HOST_WDATA[3:1], 1'b0};
		if (d_w1)
			nxt_mode1 = {4'h0, DISP_WDATA[3:1], 1'b0};
		if (h_wl)
			nxt_logic = HOST_WDATA;
		if (d_wl)
			nxt_logic = DISP_WDATA;
	end

	vwl_plane_drive u_plane (
		.logic_reg     (logic_ff),
		.fg_level      (fg),
		.bg_level      (bg),
		.plane_wr_en   (pwe),
		.op_replace    (o_rep),
		.op_overlay    (o_ovl),
		.op_complement (o_cmp)
	);

	assign se_mode = {mode1_ff[`VWL_MS1_SE_HI], mode1_ff[`VWL_MS1_SE_LO]};

	always @(posedge CLK_SYS) begin
		if (RST) begin
			mode0_ff <= `VWL_RST_MODE0;
			mode1_ff <= `VWL_RST_MODE1;
			logic_ff <= `VWL_RST_LOGIC;
			HOST_RDATA <= 8'h00;
			DISP_RDATA <= 8'h00;
		end else begin
			mode0_ff <= nxt_mode0;
			mode1_ff <= nxt_mode1;
			logic_ff <= nxt_logic;
			// Read data holds until next read; registers are write-only
			if (h_rd)
				HOST_RDATA <= status;
			if (d_rd)
				DISP_RDATA <= status;
		end
	end

	// Control outputs registered from the stored register values
	always @(posedge CLK_SYS) begin
		if (RST) begin
			SCREEN_ERASE_DISABLE <= 1'b1;
			PATTERN_SOURCE_SELECT <= 1'b0;
			READBACK_SELECT <= 1'b0;
			LOGIC_UNIT_ROUTE <= 1'b0;
			VECTOR_MODE_SELECT <= 1'b0;
			TEXT_MASK_ENABLE <= 1'b1;
			BITMAP_OUTPUT_ENABLE <= 1'b1;
			BITMAP_WRITE_ALLOW <= 1'b0;
			PLANE_MAP_SELECT <= 2'b00;
			LINE_ERASE_ENABLE <= 1'b0;
			DMA_SCROLL_ENABLE <= 1'b0;
			COUNT_DIRECTION <= 1'b0;
			FOREGROUND_LEVEL <= 2'b00;
			BACKGROUND_LEVEL <= 2'b00;
			PLANE_WRITE_ENABLE <= 2'b11;
			OP_REPLACE <= 1'b1;
			OP_OVERLAY <= 1'b0;
			OP_COMPLEMENT <= 1'b0;
		end else begin
			SCREEN_ERASE_DISABLE <= mode0_ff[`VWL_MS0_ERASE_DIS];
			PATTERN_SOURCE_SELECT <= mode0_ff[`VWL_MS0_PATSRC];
			READBACK_SELECT <= mode0_ff[`VWL_MS0_READBACK];
			LOGIC_UNIT_ROUTE <= mode0_ff[`VWL_MS0_LU_ROUTE];
			VECTOR_MODE_SELECT <= mode0_ff[`VWL_MS0_VECTOR];
			TEXT_MASK_ENABLE <= ~mode0_ff[`VWL_MS0_VECTOR];
			BITMAP_OUTPUT_ENABLE <= mode0_ff[`VWL_MS0_OUT_EN];
			BITMAP_WRITE_ALLOW <= ~mode0_ff[`VWL_MS0_OUT_EN];
			PLANE_MAP_SELECT <= {mode0_ff[`VWL_MS0_MAP_HI], mode0_ff[`VWL_MS0_MAP_LO]};
			// Unused code 01 enables neither mode
			LINE_ERASE_ENABLE <= (se_mode == `VWL_SE_LINE_ERASE);
			DMA_SCROLL_ENABLE <= (se_mode == `VWL_SE_DMA_SCROLL);
			COUNT_DIRECTION <= mode1_ff[`VWL_MS1_DIR];
			FOREGROUND_LEVEL <= fg;
			BACKGROUND_LEVEL <= bg;
			PLANE_WRITE_ENABLE <= pwe;
			OP_REPLACE <= o_rep;
			OP_OVERLAY <= o_ovl;
			OP_COMPLEMENT <= o_cmp;
		end
	end
endmodule

// ==== verification/vwl_ctrl_assertions.sv ====
// Port-level checker for the video write control block
`timescale 1ns/100ps
module vwl_ctrl_chk (
	input wire        CLK_SYS, RST, HOST_SEL, HOST_WR, DISP_SEL, DISP_WR,
	input wire [15:0] HOST_ADDR,
	input wire [7:0]  HOST_WDATA, HOST_RDATA, DISP_ADDR, DISP_WDATA, DISP_RDATA,
	input wire        HBLANK, VRETRACE, DMA_BUSY, DRAW_BUSY,
	input wire        QUEUE_EMPTY, QUEUE_FULL, DATA_READY,
	input wire        SCREEN_ERASE_DISABLE, PATTERN_SOURCE_SELECT, READBACK_SELECT,
	input wire        LOGIC_UNIT_ROUTE, VECTOR_MODE_SELECT, TEXT_MASK_ENABLE,
	input wire        BITMAP_OUTPUT_ENABLE, BITMAP_WRITE_ALLOW,
	input wire        LINE_ERASE_ENABLE, DMA_SCROLL_ENABLE, COUNT_DIRECTION,
	input wire        OP_REPLACE, OP_OVERLAY, OP_COMPLEMENT,
	input wire [1:0]  PLANE_MAP_SELECT, FOREGROUND_LEVEL, BACKGROUND_LEVEL,
	input wire [1:0]  PLANE_WRITE_ENABLE
);
	wire [7:0] st = {1'b0, HBLANK, VRETRACE, DMA_BUSY, DRAW_BUSY,
		QUEUE_EMPTY, QUEUE_FULL, DATA_READY};
	wire [7:0] ms0_out = {SCREEN_ERASE_DISABLE, PATTERN_SOURCE_SELECT, READBACK_SELECT,
		LOGIC_UNIT_ROUTE, VECTOR_MODE_SELECT, BITMAP_OUTPUT_ENABLE, PLANE_MAP_SELECT};
	wire dw = DISP_SEL && DISP_WR;
	wire hw = HOST_SEL && HOST_WR;
	// Write data two edges back, matching the output latency
	logic [7:0] dwd1, dwd2, hwd1, hwd2;
	always @(posedge CLK_SYS) begin
		dwd1 <= DISP_WDATA;
		dwd2 <= dwd1;
		hwd1 <= HOST_WDATA;
		hwd2 <= hwd1;
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_disp_status: assert property (
		DISP_SEL && !DISP_WR && DISP_ADDR == 8'h00 |=> DISP_RDATA == $past(st))
		else $error("display status read wrong");
	a_host_status: assert property (
		HOST_SEL && !HOST_WR && HOST_ADDR == 16'hf600 |=> HOST_RDATA == $past(st))
		else $error("host status read wrong");
	a_rdata_hold: assert property (
		!(DISP_SEL && !DISP_WR && DISP_ADDR == 8'h00) |=> $stable(DISP_RDATA))
		else $error("display read data changed without a read");
	a_mode0_disp: assert property (
		dw && DISP_ADDR == 8'hc0 |-> ##2 ms0_out == dwd2)
		else $error("mode outputs differ from display write");
	a_mode0_host: assert property (
		hw && HOST_ADDR == 16'hf980 && !(dw && DISP_ADDR == 8'hc0) |-> ##2 ms0_out == hwd2)
		else $error("mode outputs differ from host write");
	a_mode0_inverse: assert property (
		TEXT_MASK_ENABLE == !VECTOR_MODE_SELECT
		&& BITMAP_WRITE_ALLOW == !BITMAP_OUTPUT_ENABLE)
		else $error("text mask or write allow not inverse");
	a_scroll_mode: assert property (
		dw && DISP_ADDR == 8'hd0 |-> ##2 {LINE_ERASE_ENABLE, DMA_SCROLL_ENABLE,
		COUNT_DIRECTION} == {dwd2[3:2] == 2'b10, dwd2[3:2] == 2'b11, dwd2[1]})
		else $error("scroll or erase mode wrong");
	a_logic_fields: assert property (
		dw && DISP_ADDR == 8'hb0 |-> ##2 {FOREGROUND_LEVEL, BACKGROUND_LEVEL} == dwd2[5:2]
		&& PLANE_WRITE_ENABLE == (dwd2[1] ? {dwd2[0], !dwd2[0]} : 2'b11))
		else $error("plane levels or enables wrong");
	a_write_op: assert property (
		dw && DISP_ADDR == 8'hb0 |-> ##2 {OP_REPLACE, OP_OVERLAY, OP_COMPLEMENT}
		== {dwd2[7:6] == 2'b00, dwd2[7:6] == 2'b10, dwd2[7:6] == 2'b11})
		else $error("write operation decode wrong");
	a_host_logic: assert property (
		hw && HOST_ADDR == 16'hf960 && !(dw && DISP_ADDR == 8'hb0)
		|-> ##2 {FOREGROUND_LEVEL, BACKGROUND_LEVEL} == hwd2[5:2])
		else $error("host logic unit write lost");
	c_mode0_write: cover property (dw && DISP_ADDR == 8'hc0);
	c_host_read: cover property (HOST_SEL && !HOST_WR && HOST_ADDR == 16'hf600);
	c_scroll_on: cover property (DMA_SCROLL_ENABLE);
endmodule
bind vwl_ctrl vwl_ctrl_chk vwl_ctrl_chk_i (.*);

// ==== verification/vwl_gdc_model.sv ====
// Drawing controller state model feeding the status inputs
`timescale 1ns/100ps
module vwl_draw_model (
	input  wire       CLK_SYS,
	input  wire [6:0] pat,
	output logic [6:0] st = '0
);
	// A queue is never empty and full at once
	always @(negedge CLK_SYS)
		st <= {pat[6:2], pat[1] & ~pat[2], pat[0]};
endmodule

// ==== verification/video_write_logic_control_test.sv ====
// Self-checking testbench for the video write control block
`timescale 1ns/100ps
module video_write_logic_control_test;
	logic        CLK_SYS = 0, RST = 1, HOST_SEL = 0, HOST_WR = 0, DISP_SEL = 0, DISP_WR = 0;
	logic [15:0] HOST_ADDR = '0;
	logic [7:0]  HOST_WDATA = '0, DISP_ADDR = '0, DISP_WDATA = '0;
	logic [6:0]  pat = '0;
	wire  [6:0]  st;
	wire  [7:0]  HOST_RDATA, DISP_RDATA;
	wire HBLANK, VRETRACE, DMA_BUSY, DRAW_BUSY, QUEUE_EMPTY, QUEUE_FULL, DATA_READY;
	wire SCREEN_ERASE_DISABLE, PATTERN_SOURCE_SELECT, READBACK_SELECT, LOGIC_UNIT_ROUTE;
	wire VECTOR_MODE_SELECT, TEXT_MASK_ENABLE, BITMAP_OUTPUT_ENABLE, BITMAP_WRITE_ALLOW;
	wire LINE_ERASE_ENABLE, DMA_SCROLL_ENABLE, COUNT_DIRECTION;
	wire OP_REPLACE, OP_OVERLAY, OP_COMPLEMENT;
	wire [1:0] PLANE_MAP_SELECT, FOREGROUND_LEVEL, BACKGROUND_LEVEL, PLANE_WRITE_ENABLE;
	wire [7:0] ms0_out = {SCREEN_ERASE_DISABLE, PATTERN_SOURCE_SELECT, READBACK_SELECT,
		LOGIC_UNIT_ROUTE, VECTOR_MODE_SELECT, BITMAP_OUTPUT_ENABLE, PLANE_MAP_SELECT};
	int mismatches = 0, samples_checked = 0;
	assign {HBLANK, VRETRACE, DMA_BUSY, DRAW_BUSY, QUEUE_EMPTY, QUEUE_FULL, DATA_READY} = st;
	vwl_draw_model vwl_draw_model_i (.CLK_SYS(CLK_SYS), .pat(pat), .st(st));
	vwl_ctrl vwl_ctrl_i (.*);
	task chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// One access; returns one and a half cycles after the taking edge
	task acc(input logic h, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge CLK_SYS);
		if (h)
			{HOST_SEL, HOST_WR, HOST_ADDR, HOST_WDATA} = {1'b1, w, a, d};
		else
			{DISP_SEL, DISP_WR, DISP_ADDR, DISP_WDATA} = {1'b1, w, a[7:0], d};
		@(negedge CLK_SYS);
		HOST_SEL = 0;
		DISP_SEL = 0;
		@(negedge CLK_SYS);
	endtask
	task t_status;
		for (int i = 0; i < 7; i++) begin
			pat = 7'h01 << i;
			acc(0, 0, 16'h0000, 8'h00);
			chk(DISP_RDATA, 8'h01 << i);
			acc(1, 0, 16'hf600, 8'h00);
			chk(HOST_RDATA, 8'h01 << i);
		end
		pat = '0;
		acc(0, 0, 16'h0011, 8'h00);
		chk(DISP_RDATA, 8'h40);
		$display("status test done");
	endtask
	task t_mode0;
		logic [7:0] v [5] = '{8'h08, 8'h73, 8'hf4, 8'h00, 8'h8e};
		foreach (v[i]) begin
			acc(i[0], 1, i[0] ? 16'hf980 : 16'h00c0, v[i]);
			chk(ms0_out, v[i]);
			chk({TEXT_MASK_ENABLE, BITMAP_WRITE_ALLOW}, {~v[i][3], ~v[i][2]});
		end
		acc(0, 1, 16'h0000, 8'h55);
		acc(1, 1, 16'h00c0, 8'h55);
		chk(ms0_out, v[4]);
		$display("mode select test done");
	endtask
	task t_mode1;
		for (int i = 0; i < 8; i++) begin
			acc(i[0], 1, i[0] ? 16'hf990 : 16'h00d0, 8'(i * 2));
			chk({LINE_ERASE_ENABLE, DMA_SCROLL_ENABLE, COUNT_DIRECTION},
				{i[2:1] == 2'b10, i[2:1] == 2'b11, i[0]});
		end
		$display("scroll mode test done");
	endtask
	task t_logic;
		logic [7:0] v;
		for (int i = 0; i < 16; i++) begin
			v = {i[3:0], i[3:0]};
			acc(i[2], 1, i[2] ? 16'hf960 : 16'h00b0, v);
			chk({FOREGROUND_LEVEL, BACKGROUND_LEVEL, PLANE_WRITE_ENABLE},
				{v[5:2], v[1] ? {v[0], ~v[0]} : 2'b11});
			chk({OP_REPLACE, OP_OVERLAY, OP_COMPLEMENT},
				{v[7:6] == 2'b00, v[7:6] == 2'b10, v[7:6] == 2'b11});
		end
		$display("logic unit test done");
	endtask
	task t_clash;
		@(negedge CLK_SYS);
		{HOST_SEL, HOST_WR, HOST_ADDR, HOST_WDATA} = {2'b11, 16'hf980, 8'h01};
		{DISP_SEL, DISP_WR, DISP_ADDR, DISP_WDATA} = {2'b11, 8'hc0, 8'h06};
		@(negedge CLK_SYS);
		HOST_SEL = 0;
		DISP_SEL = 0;
		@(negedge CLK_SYS);
		chk(ms0_out, 8'h06);
		$display("write clash test done");
	endtask
	// Processor-side programming: text mode, then vector mode with replace writing
	task t_recipe;
		acc(0, 1, 16'h00c0, 8'h94);
		acc(0, 1, 16'h00b0, 8'h30);
		chk({VECTOR_MODE_SELECT, TEXT_MASK_ENABLE, LOGIC_UNIT_ROUTE}, 8'h03);
		chk({OP_REPLACE, FOREGROUND_LEVEL}, 8'h07);
		acc(1, 1, 16'hf980, 8'h9c);
		chk({VECTOR_MODE_SELECT, TEXT_MASK_ENABLE, OP_REPLACE}, 8'h05);
		$display("recipe test done");
	endtask
	task t_reset;
		RST = 1;
		repeat (2) @(negedge CLK_SYS);
		RST = 0;
		chk(ms0_out, 8'h84);
		chk({FOREGROUND_LEVEL, BACKGROUND_LEVEL, PLANE_WRITE_ENABLE}, 8'h03);
		chk({OP_REPLACE, OP_OVERLAY, OP_COMPLEMENT, DISP_RDATA[0]}, 8'h08);
		$display("reset test done");
	endtask
	task report_and_stop;
		$display("checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		forever #50 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		repeat (2) @(negedge CLK_SYS);
		RST = 0;
		t_status;
		t_mode0;
		t_mode1;
		t_logic;
		t_clash;
		t_recipe;
		t_reset;
		report_and_stop;
	end
	// Whole run needs about 154 cycles
	initial begin
		repeat (3000) @(posedge CLK_SYS);
		mismatches++;
		report_and_stop;
	end
endmodule
